/* File: rtl/bsi_scan_logic.sv */
`timescale 1ns/1ps
`default_nettype none

module bsi_scan_logic #(
  parameter int NPINS = 8,
  parameter int NTWI = 2,
  parameter int TIMEOUT_CYC = bsi_pkg::RESET_TIMEOUT_CYC,
  parameter logic [3:0] ID_VERSION = 4'h0, // Arbitrary value
  parameter logic [15:0] ID_PART = 16'h1234, // Arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h055 // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic testClk,
  input wire logic testDataIn,
  output logic testDataOut,
  input wire bsi_pkg::bsi_tap_t tapCtrl,
  input wire logic test_port_enable_fuse,
  input wire logic test_port_disable_bit,
  input wire logic global_pullup_disable,
  input wire logic [NPINS-1:0] pin_direction_bit,
  input wire logic [NPINS-1:0] pin_output_bit,
  input wire logic [NPINS-1:0] pinPad,
  input wire logic [NTWI-1:0] twowire_driver_enable,
  output logic [NPINS-1:0] padOut,
  output logic [NPINS-1:0] padOe,
  output logic [NPINS-1:0] padPullup,
  output logic [NTWI-1:0] twiDriveEn,
  output logic systemReset,
  output logic [3:0] activeOpcode
);

  localparam int CHAIN_LEN = NPINS * bsi_pkg::CELLS_PER_PIN + NTWI;
  localparam int TW = $clog2(TIMEOUT_CYC + 1);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  // Two-wire cells need a non-empty vector; the hold check needs two counts
  if (NPINS < 1 || NTWI < 1 || TIMEOUT_CYC < 2)
  begin
    $error("bsi_scan_logic: bad parameter");
  end

  // ------------------------------------------------------------
  // Synchronisers for link clock, serial input, strobes and pins
  // ------------------------------------------------------------
  logic [2:0] tckSync_ff;
  logic [1:0] tdiSync_ff;
  logic [6:0] tapS1_ff;
  logic [6:0] tapS2_ff;
  logic [NPINS-1:0] pinS1_ff;
  logic [NPINS-1:0] pinS2_ff;
  logic [1:0] enS1_ff;
  logic [1:0] enS2_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tckSync_ff <= 3'h0;
      tdiSync_ff <= 2'h0;
      tapS1_ff <= 7'h00;
      tapS2_ff <= 7'h00;
      pinS1_ff <= '0;
      pinS2_ff <= '0;
      enS1_ff <= 2'h0;
      enS2_ff <= 2'h0;
    end
    else
    begin
      tckSync_ff <= {tckSync_ff[1:0], testClk};
      tdiSync_ff <= {tdiSync_ff[0], testDataIn};
      tapS1_ff <= tapCtrl;
      tapS2_ff <= tapS1_ff;
      pinS1_ff <= pinPad;
      pinS2_ff <= pinS1_ff;
      enS1_ff <= {test_port_enable_fuse, test_port_disable_bit};
      enS2_ff <= enS1_ff;
    end
  end

  // Edge detect reads only the second and third stages
  bsi_pkg::bsi_tap_t tap;
  wire tckRise = tckSync_ff[1] & ~tckSync_ff[2];
  wire tdi = tdiSync_ff[1];
  wire portOn = enS2_ff[1] & ~enS2_ff[0];
  assign tap = bsi_pkg::bsi_tap_t'(tapS2_ff);
  wire act = tckRise & portOn;

  // ------------------------------------------------------------
  // Instruction register and decode
  // ------------------------------------------------------------
  logic [3:0] irShift_ff;
  logic [3:0] ir_ff;
  logic bypass_ff;
  logic rstReg_ff;
  logic [31:0] idShift_ff;
  logic [CHAIN_LEN-1:0] chain_ff;
  logic [CHAIN_LEN-1:0] latch_ff;

  wire selChain = (ir_ff == bsi_pkg::OP_EXTEST) || (ir_ff == bsi_pkg::OP_SAMPLE);
  wire selId = ir_ff == bsi_pkg::OP_IDCODE;
  wire selRst = ir_ff == bsi_pkg::OP_RESET;
  wire selByp = !(selChain || selId || selRst);
  wire extest = ir_ff == bsi_pkg::OP_EXTEST;

  // Identification word with the constant one at bit zero
  wire [31:0] idWord = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  // Capture vector: per pin pull-up, control, input sample; two-wire enables
  function automatic logic [CHAIN_LEN-1:0] capVec(input logic [NPINS-1:0] pins);
    logic [CHAIN_LEN-1:0] v;
    v = '0;
    for (int i = 0; i < NPINS; i++)
    begin
      v[i*3 + bsi_pkg::CELL_PULLUP] = ~global_pullup_disable & ~pin_direction_bit[i]
        & pin_output_bit[i];
      v[i*3 + bsi_pkg::CELL_CTRL] = pin_direction_bit[i];
      v[i*3 + bsi_pkg::CELL_DATA] = pins[i];
    end
    for (int t = 0; t < NTWI; t++)
    begin
      v[NPINS*3 + t] = twowire_driver_enable[t];
    end
    return v;
  endfunction

  // Instruction and data paths; every path shifts LSB first
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irShift_ff <= 4'h0;
      ir_ff <= bsi_pkg::IR_RESET_VALUE;
      bypass_ff <= 1'b0;
      rstReg_ff <= 1'b0;
      idShift_ff <= 32'h0;
      chain_ff <= '0;
      latch_ff <= '0;
    end
    else if (act)
    begin
      if (tap.testReset)
        ir_ff <= bsi_pkg::IR_RESET_VALUE;
      if (tap.captureIr)
        irShift_ff <= {2'h0, bsi_pkg::IR_CAPTURE_VALUE};
      if (tap.shiftIr)
        irShift_ff <= {tdi, irShift_ff[3:1]};
      if (tap.updateIr)
        ir_ff <= irShift_ff;
      if (tap.captureDr && selByp)
        bypass_ff <= 1'b0;
      if (tap.shiftDr && selByp)
        bypass_ff <= tdi;
      if (tap.shiftDr && selRst)
        rstReg_ff <= tdi;
      if (tap.captureDr && selId)
        idShift_ff <= idWord;
      if (tap.shiftDr && selId)
        idShift_ff <= {tdi, idShift_ff[31:1]};
      if (tap.captureDr && selChain)
        chain_ff <= capVec(pinS2_ff);
      if (tap.shiftDr && selChain)
        chain_ff <= {tdi, chain_ff[CHAIN_LEN-1:1]};
      if (tap.updateDr && selChain)
        latch_ff <= chain_ff;
    end
  end

  // ------------------------------------------------------------
  // Serial output mux, registered
  // ------------------------------------------------------------
  wire tdoNext = selChain ? chain_ff[0] : selId ? idShift_ff[0] :
    selRst ? rstReg_ff : bypass_ff;

  // ------------------------------------------------------------
  // System reset hold with time-out after release
  // ------------------------------------------------------------
  logic [TW-1:0] tmo_ff;
  wire [TW-1:0] tmoMax = TW'(TIMEOUT_CYC);
  wire [TW-1:0] nxt_tmo = (rstReg_ff && portOn) ? tmoMax :
    (tmo_ff != '0) ? tmo_ff - 1'b1 : tmo_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tmo_ff <= '0;
      testDataOut <= 1'b0;
      systemReset <= 1'b0;
      activeOpcode <= bsi_pkg::IR_RESET_VALUE;
    end
    else
    begin
      tmo_ff <= nxt_tmo;
      testDataOut <= tdoNext;
      systemReset <= (rstReg_ff && portOn) || (tmo_ff != '0);
      activeOpcode <= ir_ff;
    end
  end

  // ------------------------------------------------------------
  // Pin drive: chain latches take the pins only under external test
  // ------------------------------------------------------------
  logic [NPINS-1:0] nxt_out;
  logic [NPINS-1:0] nxt_oe;
  logic [NPINS-1:0] nxt_pu;
  logic [NTWI-1:0] nxt_twi;
  wire drivePins = extest && portOn;

  always_comb
  begin
    for (int i = 0; i < NPINS; i++)
    begin
      nxt_pu[i] = drivePins ? latch_ff[i*3 + bsi_pkg::CELL_PULLUP] :
        ~global_pullup_disable & ~pin_direction_bit[i] & pin_output_bit[i];
      nxt_oe[i] = drivePins ? latch_ff[i*3 + bsi_pkg::CELL_CTRL] : pin_direction_bit[i];
      nxt_out[i] = drivePins ? latch_ff[i*3 + bsi_pkg::CELL_DATA] : pin_output_bit[i];
    end
    for (int t = 0; t < NTWI; t++)
    begin
      nxt_twi[t] = drivePins ? latch_ff[NPINS*3 + t] : twowire_driver_enable[t];
    end
  end

  // System reset tri-states pins except under external test, standing in for a high-impedance opcode
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      padOut <= '0;
      padOe <= '0;
      padPullup <= '0;
      twiDriveEn <= '0;
    end
    else
    begin
      padOut <= nxt_out;
      padOe <= (systemReset && !drivePins) ? '0 : nxt_oe;
      padPullup <= (systemReset && !drivePins) ? '0 : nxt_pu;
      twiDriveEn <= (systemReset && !drivePins) ? '0 : nxt_twi;
    end
  end

  // Output-control bits of the latches, so the drive check stays independent
  function automatic logic [NPINS-1:0] latchCtrl(input logic [CHAIN_LEN-1:0] l);
    logic [NPINS-1:0] v;
    v = '0;
    for (int i = 0; i < NPINS; i++)
    begin
      v[i] = l[i*3 + bsi_pkg::CELL_CTRL];
    end
    return v;
  endfunction

  wire [NPINS-1:0] latchOe = latchCtrl(latch_ff);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_reset_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (rstReg_ff && portOn) |=> systemReset) else $error("reset not held");
  a_timeout_hold: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(rstReg_ff) && portOn |=> systemReset[*2]) else $error("time-out cut");
  a_bypass_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (act && tap.captureDr && selByp && !tap.shiftDr) |=> !bypass_ff) else $error("bypass");
  a_id_capture: assert property (@(posedge clk) disable iff (!rst_n)
    (act && tap.captureDr && selId && !tap.shiftDr) |=> idShift_ff == idWord)
    else $error("id capture");
  a_id_lsb_one: assert property (@(posedge clk) disable iff (!rst_n)
    (act && tap.captureDr && selId && !tap.shiftDr) |=> ##1 testDataOut)
    else $error("id bit zero");
  a_extest_drive: assert property (@(posedge clk) disable iff (!rst_n)
    drivePins |=> padOe == $past(latchOe)) else $error("extest drive");
  a_sample_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (ir_ff == bsi_pkg::OP_SAMPLE && !systemReset) |=> padOut == $past(pin_output_bit))
    else $error("sample disturbs pins");
  a_port_off: assert property (@(posedge clk) disable iff (!rst_n)
    !portOn |=> $stable(ir_ff)) else $error("port active while disabled");
  a_ir_shift: assert property (@(posedge clk) disable iff (!rst_n)
    (act && tap.shiftIr && !tap.updateIr && !tap.captureIr) |=> irShift_ff[3] == $past(tdi))
    else $error("ir shift order");

endmodule

`default_nettype wire

/* File: rtl/bsi_pkg.sv */
package bsi_pkg;

  // ------------------------------------------------------------
  // Instruction opcodes
  // ------------------------------------------------------------
  localparam int IR_WIDTH = 4;
  localparam logic [3:0] OP_EXTEST = 4'h0;
  localparam logic [3:0] OP_IDCODE = 4'h1;
  localparam logic [3:0] OP_SAMPLE = 4'h2;
  localparam logic [3:0] OP_RESET = 4'hC;
  localparam logic [3:0] OP_BYPASS = 4'hF;
  localparam logic [3:0] IR_RESET_VALUE = 4'h1;
  localparam logic [1:0] IR_CAPTURE_VALUE = 2'h1;

  // ------------------------------------------------------------
  // Identification word layout
  // ------------------------------------------------------------
  localparam int ID_WIDTH = 32;
  localparam int ID_VER_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MFR_LSB = 1;
  localparam int ID_VER_W = 4;
  localparam int ID_PART_W = 16;
  localparam int ID_MFR_W = 11;

  // ------------------------------------------------------------
  // Chain layout: per port pin three stages, two-wire enables last
  // ------------------------------------------------------------
  localparam int CELLS_PER_PIN = 3;
  localparam int CELL_PULLUP = 0;
  localparam int CELL_CTRL = 1;
  localparam int CELL_DATA = 2;

  // ------------------------------------------------------------
  // Reset time-out after the reset register clears
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int RESET_TIMEOUT_US = 65;
  localparam int RESET_TIMEOUT_CYC = RESET_TIMEOUT_US * CLK_MHZ;

  // Test controller strobes, each held as a level through one link clock period
  typedef struct packed {
    logic captureIr;
    logic shiftIr;
    logic updateIr;
    logic captureDr;
    logic shiftDr;
    logic updateDr;
    logic testReset;
  } bsi_tap_t;

endpackage

/* File: verif/bsi_tap_model.sv */
`timescale 1ns/1ps
`default_nettype none

// --------------------------------
// Test controller model
// --------------------------------
// Link clock rests low between frames, 450 ns per period
module bsi_tap_model (
  input wire logic clk,
  input wire logic testDataOut,
  output logic testClk,
  output logic testDataIn,
  output bsi_pkg::bsi_tap_t tapCtrl
);
  initial
  begin
    testClk = 1'b0;
    testDataIn = 1'b0;
    tapCtrl = '0;
  end

  // One period; serial output read just before the rise
  task automatic tick(input bsi_pkg::bsi_tap_t c, input logic d, output logic q);
    @(posedge clk);
    #2;
    tapCtrl = c;
    testDataIn = d;
    repeat (4) @(posedge clk);
    #2;
    q = testDataOut;
    testClk = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    testClk = 1'b0;
    tapCtrl = '0;
    testDataIn = ~d; // Idle line must not look held
  endtask

  // Opcode goes out least significant bit first
  task automatic scan_ir(input logic [3:0] op);
    bsi_pkg::bsi_tap_t c;
    logic q;
    c = '0;
    c.captureIr = 1'b1;
    tick(c, 1'b0, q);
    c = '0;
    c.shiftIr = 1'b1;
    for (int i = 0; i < 4; i++)
      tick(c, op[i], q);
    c = '0;
    c.updateIr = 1'b1;
    tick(c, 1'b0, q);
  endtask

  // Data scan of n stages, both directions least significant bit first
  task automatic scan_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    bsi_pkg::bsi_tap_t c;
    logic q;
    dout = '0;
    c = '0;
    c.captureDr = 1'b1;
    tick(c, 1'b0, q);
    c = '0;
    c.shiftDr = 1'b1;
    for (int i = 0; i < n; i++)
      tick(c, din[i], dout[i]);
    c = '0;
    c.updateDr = 1'b1;
    tick(c, 1'b0, q);
  endtask
endmodule

`default_nettype wire

/* File: verif/bsi_scan_logic_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module bsi_scan_logic_tb_top;
  // --------------------------------
  // Bench setup
  // --------------------------------
  localparam int TMO = 20; // Short time-out keeps the run brief
  localparam logic [31:0] IDW = {4'h3, 16'hA5C3, 11'h2B4, 1'b1}; // Arbitrary identity
  typedef struct {logic [3:0] op; int n; logic [31:0] din; logic [31:0] dout;} bsi_row_t;
  bsi_row_t rows[4] = '{
    '{bsi_pkg::OP_BYPASS, 2, 32'h3, 32'h2},
    '{4'h5, 2, 32'h3, 32'h2},
    '{4'h7, 2, 32'h1, 32'h2},
    '{bsi_pkg::OP_SAMPLE, 7, 32'h16, 32'h6A}};
  logic clk, rst_n, testClk, testDataIn, testDataOut, fuse, dis, gpd, sysRst;
  bsi_pkg::bsi_tap_t tapCtrl;
  logic [1:0] dir, pob, pad, padOut, padOe, padPullup;
  logic [0:0] twe, twiDriveEn;
  logic [3:0] op;
  logic [31:0] d;
  int errors = 0;
  int samplesChecked = 0;
  int cycles = 0;
  wire logic [31:0] pins = {25'h0, padOe, padOut, padPullup, twiDriveEn};

  bsi_scan_logic #(.NPINS(2), .NTWI(1), .TIMEOUT_CYC(TMO), .ID_VERSION(4'h3),
    .ID_PART(16'hA5C3), .ID_MAKER(11'h2B4)) dut (.clk(clk), .rst_n(rst_n),
    .testClk(testClk), .testDataIn(testDataIn), .testDataOut(testDataOut),
    .tapCtrl(tapCtrl), .test_port_enable_fuse(fuse), .test_port_disable_bit(dis),
    .global_pullup_disable(gpd), .pin_direction_bit(dir), .pin_output_bit(pob),
    .pinPad(pad), .twowire_driver_enable(twe), .padOut(padOut), .padOe(padOe),
    .padPullup(padPullup), .twiDriveEn(twiDriveEn), .systemReset(sysRst),
    .activeOpcode(op));

  bsi_tap_model tap (.clk(clk), .testDataOut(testDataOut), .testClk(testClk),
    .testDataIn(testDataIn), .tapCtrl(tapCtrl));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard; the whole sequence needs well under this
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      errors++;
      complete_run();
    end
  end

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // --------------------------------
  // Sequence
  // --------------------------------
  initial
  begin
    rst_n = 1'b0;
    fuse = 1'b1;
    dis = 1'b0;
    gpd = 1'b0;
    dir = 2'b01;
    pob = 2'b11;
    pad = 2'b10;
    twe = 1'b1;
    repeat (5) @(posedge clk);
    #2;
    check("opcode", 32'h1, {28'h0, op});
    check("sys_reset", 32'h0, {31'h0, sysRst});
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    tap.scan_dr(32, 32'h0, d);
    check("idcode", IDW, d);
    $display("test reset_id done");
    foreach (rows[i])
    begin
      tap.scan_ir(rows[i].op);
      check("opcode", {28'h0, rows[i].op}, {28'h0, op});
      tap.scan_dr(rows[i].n, rows[i].din, d);
      check("dr_out", rows[i].dout, d);
    end
    check("pins", 32'h3D, pins);
    $display("test table done");
    tap.scan_ir(bsi_pkg::OP_EXTEST);
    check("pins", 32'h68, pins);
    // Pin 0 control low while the two-wire enable is set: no contention
    tap.scan_dr(7, 32'h61, d);
    check("pins", 32'h13, pins);
    $display("test extest done");
    tap.scan_ir(bsi_pkg::OP_RESET);
    tap.scan_dr(1, 32'h1, d);
    check("sys_reset", 32'h1, {31'h0, sysRst});
    // System reset floats every pin and drops pull-ups and two-wire drive
    check("pins", 32'h18, pins);
    check("opcode", 32'hC, {28'h0, op});
    tap.scan_dr(1, 32'h0, d);
    check("sys_reset", 32'h1, {31'h0, sysRst});
    repeat (TMO + 10) @(posedge clk);
    #2;
    check("sys_reset", 32'h0, {31'h0, sysRst});
    $display("test reset_reg done");
    dis = 1'b1;
    tap.scan_ir(bsi_pkg::OP_BYPASS);
    check("opcode", 32'hC, {28'h0, op});
    dis = 1'b0;
    fuse = 1'b0;
    tap.scan_ir(bsi_pkg::OP_BYPASS);
    check("opcode", 32'hC, {28'h0, op});
    fuse = 1'b1;
    tap.scan_ir(bsi_pkg::OP_BYPASS);
    check("opcode", 32'hF, {28'h0, op});
    $display("test enable done");
    // Mid-run reset must bring back the identification instruction
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    check("opcode", 32'h1, {28'h0, op});
    check("sys_reset", 32'h0, {31'h0, sysRst});
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    tap.scan_dr(32, 32'h0, d);
    check("idcode", IDW, d);
    $display("test mid_reset done");
    complete_run();
  end
endmodule

`default_nettype wire
